// ==== hdl/seg_xlate.sv ====
// Segment translation unit: selector and offset to linear address, APB controlled
//
// Notes on behaviour
// - Reset always leaves unit in real mode
// - Protected accesses go through a table descriptor
// - Descriptor yields base, rights, type, usage
// - Selector splits into index, table flag, rights
// - Linear address is descriptor base plus offset
// - Access needs valid segment and adequate privilege
// - Current level follows the loaded code segment
// - Selector goes through a table lookup except in real mode or when it is null
// - Global and local table bases held here
// - Table bases are 64 bits in extended mode
// - 64-bit sub-mode local entries take 16 bytes
// - Compatibility sub-mode keeps legacy descriptor size
// - Extended mode has exactly two sub-modes
// - Some exceptions carry an error code
// - Inaccurate error code is reported as zero
// - Division by zero raises an exception
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module seg_xlate
  import seg_xlate_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Descriptor fetch from system memory
  output logic mem_req,
  output logic [63:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  // Divide unit check
  input wire logic div_op,
  input wire logic [31:0] div_divisor,
  // Exception report
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output logic [31:0] exc_code
);

  mode_t mode, next_mode;
  xlate_state_t st, next_st;
  logic [63:0] gt_base, next_gt_base;
  logic [63:0] lt_base, next_lt_base;
  logic [16:0] sel_reg, next_sel_reg;
  logic [63:0] off, next_off;
  logic done, next_done;
  logic fault, next_fault;
  logic [7:0] vec, next_vec;
  logic [31:0] err, next_err;
  logic [63:0] lin, next_lin;
  logic [1:0] current_privilege_level, next_cpl;
  desc_attr_t attr, next_attr;
  logic [63:0] word0, next_word0;
  logic [63:0] word1, next_word1;
  logic div_pend, next_div_pend;
  logic next_mem_req;
  logic [63:0] next_mem_addr;
  logic next_exc_valid;
  logic [7:0] next_exc_vector;
  logic [31:0] next_exc_code;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  selector_t sel;
  logic wr, ext, wide, null_sel, priv_ok, seg_ok;
  logic [1:0] eff_level;
  logic [63:0] tbase, desc_addr, dbase;
  logic [20:0] real_lin;
  desc_attr_t dattr;

  // Selector fields and table base selection
  assign sel = selector_t'(sel_reg[15:0]);
  assign ext = mode[1];
  assign wide = (mode == MODE_EXT64) && sel.table_local;
  assign tbase = sel.table_local ? (ext ? lt_base : {32'h0000_0000, lt_base[31:0]})
                                 : (ext ? gt_base : {32'h0000_0000, gt_base[31:0]});
  assign desc_addr = tbase + (wide ? {47'h0, sel.index, 4'h0} : {48'h0, sel.index, 3'h0});
  assign null_sel = (sel.index == 13'h0000) && !sel.table_local;
  assign real_lin = {1'b0, sel_reg[15:0], 4'h0} + {5'h00, off[15:0]};
  assign wr = psel && penable && pready && pwrite;

  // Privilege test against the larger of current and requested level
  assign eff_level = (current_privilege_level > sel.req_level) ? current_privilege_level : sel.req_level;
  assign priv_ok = (eff_level <= dattr.dpl);
  assign seg_ok = dattr.present && dattr.code_data && priv_ok;

  seg_desc_decode u_decode (
    .word_lo(word0),
    .word_hi(word1),
    .wide(wide),
    .base(dbase),
    .attr(dattr)
  );

  // Register writes, mode control and the translation sequencer
  always_comb begin
    next_mode = mode;
    next_st = st;
    next_gt_base = gt_base;
    next_lt_base = lt_base;
    next_sel_reg = sel_reg;
    next_off = off;
    next_done = done;
    next_fault = fault;
    next_vec = vec;
    next_err = err;
    next_lin = lin;
    next_cpl = current_privilege_level;
    next_attr = attr;
    next_word0 = word0;
    next_word1 = word1;
    next_div_pend = div_pend;
    next_mem_req = mem_req;
    next_mem_addr = mem_addr;
    next_exc_valid = 1'b0;
    next_exc_vector = exc_vector;
    next_exc_code = exc_code;
    if (wr && st == ST_IDLE) begin
      unique case (paddr)
        ADDR_MODE: begin
          // Extended sub-modes are reachable only from protected or extended
          if (!(pwdata[1] && mode == MODE_REAL)) begin
            next_mode = mode_t'(pwdata[1:0]);
          end
        end
        ADDR_GT_LO: next_gt_base[31:0] = pwdata;
        ADDR_GT_HI: next_gt_base[63:32] = pwdata;
        ADDR_LT_LO: next_lt_base[31:0] = pwdata;
        ADDR_LT_HI: next_lt_base[63:32] = pwdata;
        ADDR_SEL: next_sel_reg = pwdata[16:0];
        ADDR_OFF_LO: next_off[31:0] = pwdata;
        ADDR_OFF_HI: next_off[63:32] = pwdata;
        default: ;
      endcase
    end
    unique case (st)
      ST_IDLE: begin
        if (wr && paddr == ADDR_CMD && pwdata[0]) begin
          next_done = 1'b0;
          next_fault = 1'b0;
          if (mode == MODE_REAL) begin
            next_lin = {43'h0, real_lin};
            next_cpl = RST_CPL;
            next_done = 1'b1;
          end else if (null_sel) begin
            next_fault = 1'b1;
            next_vec = VEC_GP;
            next_err = 32'h0000_0000;
            next_exc_valid = 1'b1;
            next_exc_vector = VEC_GP;
            next_exc_code = 32'h0000_0000;
          end else begin
            next_mem_req = 1'b1;
            next_mem_addr = desc_addr;
            next_st = ST_FETCH0;
          end
        end
      end
      ST_FETCH0: begin
        if (mem_ack) begin
          next_word0 = mem_rdata;
          next_word1 = 64'h0000_0000_0000_0000;
          if (wide) begin
            next_mem_addr = mem_addr + DESC_HALF_STEP;
            next_st = ST_FETCH1;
          end else begin
            next_mem_req = 1'b0;
            next_st = ST_CHECK;
          end
        end
      end
      ST_FETCH1: begin
        if (mem_ack) begin
          next_word1 = mem_rdata;
          next_mem_req = 1'b0;
          next_st = ST_CHECK;
        end
      end
      ST_CHECK: begin
        next_st = ST_IDLE;
        next_attr = dattr;
        if (seg_ok) begin
          next_done = 1'b1;
          if (mode == MODE_EXT64) begin
            next_lin = dbase + off;
          end else begin
            next_lin = {32'h0000_0000, dbase[31:0] + off[31:0]};
          end
          if (sel_reg[SEL_CODE_LOAD_BIT]) begin
            next_cpl = dattr.dpl;
          end
        end else begin
          next_fault = 1'b1;
          next_vec = VEC_GP;
          next_err = {16'h0000, sel_reg[15:2], 2'b00};
          next_exc_valid = 1'b1;
          next_exc_vector = VEC_GP;
          next_exc_code = {16'h0000, sel_reg[15:2], 2'b00};
        end
      end
    endcase
    // Divide check shares the exception port; a collision is held one cycle
    if ((div_op && div_divisor == 32'h0000_0000) || div_pend) begin
      if (next_exc_valid) begin
        next_div_pend = 1'b1;
      end else begin
        next_div_pend = 1'b0;
        next_exc_valid = 1'b1;
        next_exc_vector = VEC_DE;
        next_exc_code = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_REAL;
      st <= ST_IDLE;
      gt_base <= RST_BASE;
      lt_base <= RST_BASE;
      sel_reg <= 17'h0_0000;
      off <= 64'h0000_0000_0000_0000;
      done <= 1'b0;
      fault <= 1'b0;
      vec <= 8'h00;
      err <= 32'h0000_0000;
      lin <= 64'h0000_0000_0000_0000;
      current_privilege_level <= RST_CPL;
      attr <= desc_attr_t'(8'h00);
      word0 <= 64'h0000_0000_0000_0000;
      word1 <= 64'h0000_0000_0000_0000;
      div_pend <= 1'b0;
      mem_req <= 1'b0;
      mem_addr <= 64'h0000_0000_0000_0000;
      exc_valid <= 1'b0;
      exc_vector <= 8'h00;
      exc_code <= 32'h0000_0000;
    end else begin
      mode <= next_mode;
      st <= next_st;
      gt_base <= next_gt_base;
      lt_base <= next_lt_base;
      sel_reg <= next_sel_reg;
      off <= next_off;
      done <= next_done;
      fault <= next_fault;
      vec <= next_vec;
      err <= next_err;
      lin <= next_lin;
      current_privilege_level <= next_cpl;
      attr <= next_attr;
      word0 <= next_word0;
      word1 <= next_word1;
      div_pend <= next_div_pend;
      mem_req <= next_mem_req;
      mem_addr <= next_mem_addr;
      exc_valid <= next_exc_valid;
      exc_vector <= next_exc_vector;
      exc_code <= next_exc_code;
    end
  end

  // APB read data is captured in the setup cycle; every access has one wait-free access phase
  always_comb begin
    next_pready = psel && !penable;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        ADDR_MODE: next_prdata = {30'h0000_0000, mode};
        ADDR_GT_LO: next_prdata = gt_base[31:0];
        ADDR_GT_HI: next_prdata = gt_base[63:32];
        ADDR_LT_LO: next_prdata = lt_base[31:0];
        ADDR_LT_HI: next_prdata = lt_base[63:32];
        ADDR_SEL: next_prdata = {15'h0000, sel_reg};
        ADDR_OFF_LO: next_prdata = off[31:0];
        ADDR_OFF_HI: next_prdata = off[63:32];
        ADDR_CMD: next_prdata = 32'h0000_0000;
        ADDR_STATUS: begin
          next_prdata[STAT_BUSY_BIT] = (st != ST_IDLE);
          next_prdata[STAT_DONE_BIT] = done;
          next_prdata[STAT_FAULT_BIT] = fault;
          next_prdata[STAT_VEC_LSB +: 8] = vec;
        end
        ADDR_ERRCODE: next_prdata = has_error_code(vec) ? err : 32'h0000_0000;
        ADDR_LIN_LO: next_prdata = lin[31:0];
        ADDR_LIN_HI: next_prdata = lin[63:32];
        ADDR_CPL: next_prdata = {30'h0000_0000, current_privilege_level};
        ADDR_ATTR: next_prdata = {24'h00_0000, attr};
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_first_ack;
    st == ST_FETCH0 && mem_ack && wide;
  endsequence
  sequence s_second_fetch;
    st == ST_FETCH1 && mem_req && mem_addr == $past(mem_addr) + DESC_HALF_STEP;
  endsequence

  a_reset_real_mode: assert property (!$past(presetn) |-> mode == MODE_REAL)
    else $error("mode after reset is not real mode");
  a_ext_from_prot: assert property ($changed(mode) && mode[1] |-> $past(mode) != MODE_REAL)
    else $error("extended mode entered from real mode");
  a_prot_fetches: assert property (wr && paddr == ADDR_CMD && pwdata[0] && st == ST_IDLE
    && mode != MODE_REAL && !null_sel |=> mem_req && mem_addr == $past(desc_addr))
    else $error("protected access did not fetch its descriptor");
  a_wide_fetch: assert property (s_first_ack |=> s_second_fetch)
    else $error("wide descriptor second half not fetched");
  a_compat_single: assert property (st == ST_FETCH0 && mem_ack && mode == MODE_COMPAT
    |=> st == ST_CHECK && !mem_req)
    else $error("compatibility descriptor fetched as wide");
  a_fault_no_xlate: assert property (exc_valid && exc_vector == VEC_GP |-> fault && !done && $stable(lin))
    else $error("faulting access changed the linear address");
  a_null_code_zero: assert property (exc_valid && exc_vector == VEC_GP && exc_code[15:2] == 14'h0000
    |-> exc_code == 32'h0000_0000)
    else $error("null selector fault has nonzero code");
  a_div_zero_exc: assert property (div_op && div_divisor == 32'h0000_0000
    |-> ##[1:2] exc_valid && exc_vector == VEC_DE)
    else $error("divide by zero raised no exception");
  a_cpl_follows_code: assert property ($changed(current_privilege_level) |-> (current_privilege_level == attr.dpl && done) || mode == MODE_REAL)
    else $error("current level changed without a code load");
  a_real_linear: assert property (done && $rose(done) && mode == MODE_REAL
    |-> lin == {43'h0, $past(real_lin)})
    else $error("real mode linear address wrong");
  a_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("APB access phase not one cycle");

endmodule : seg_xlate

// ==== hdl/seg_xlate_pkg.sv ====
// Shared types, register map and constants for the segment translation unit
package seg_xlate_pkg;

  // Operating modes; the top bit marks the extended mode with its two sub-modes
  typedef enum logic [1:0] {
    MODE_REAL   = 2'b00,
    MODE_PROT   = 2'b01,
    MODE_EXT64  = 2'b10,
    MODE_COMPAT = 2'b11
  } mode_t;

  // Translation sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FETCH0 = 2'b01,
    ST_FETCH1 = 2'b10,
    ST_CHECK  = 2'b11
  } xlate_state_t;

  // Selector layout: table index, table choice, requested level
  typedef struct packed {
    logic [12:0] index;
    logic table_local;
    logic [1:0] req_level;
  } selector_t;

  // Descriptor attributes as returned to software
  typedef struct packed {
    logic present;
    logic [1:0] dpl;
    logic code_data;
    logic [3:0] seg_type;
  } desc_attr_t;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_GT_LO = 8'h04;
  localparam logic [7:0] ADDR_GT_HI = 8'h08;
  localparam logic [7:0] ADDR_LT_LO = 8'h0C;
  localparam logic [7:0] ADDR_LT_HI = 8'h10;
  localparam logic [7:0] ADDR_SEL = 8'h14;
  localparam logic [7:0] ADDR_OFF_LO = 8'h18;
  localparam logic [7:0] ADDR_OFF_HI = 8'h1C;
  localparam logic [7:0] ADDR_CMD = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_ERRCODE = 8'h28;
  localparam logic [7:0] ADDR_LIN_LO = 8'h2C;
  localparam logic [7:0] ADDR_LIN_HI = 8'h30;
  localparam logic [7:0] ADDR_CPL = 8'h34;
  localparam logic [7:0] ADDR_ATTR = 8'h38;

  // Field positions
  localparam int SEL_CODE_LOAD_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_FAULT_BIT = 2;
  localparam int STAT_VEC_LSB = 8;

  // Reset values
  localparam logic [63:0] RST_BASE = 64'h0000_0000_0000_0000;
  localparam logic [1:0] RST_CPL = 2'h0;

  // Exception vectors
  localparam logic [7:0] VEC_DE = 8'h00;
  localparam logic [7:0] VEC_GP = 8'h0D;
  localparam logic [7:0] VEC_PF = 8'h0E;

  // Step between the two halves of a wide descriptor
  localparam logic [63:0] DESC_HALF_STEP = 64'h0000_0000_0000_0008;

  // Vectors that push an error code
  function automatic logic has_error_code(input logic [7:0] vec);
    has_error_code = (vec == VEC_GP) || (vec == VEC_PF);
  endfunction : has_error_code

endpackage : seg_xlate_pkg

// ==== hdl/seg_desc_decode.sv ====
// Descriptor field extraction for legacy and wide descriptor formats
`timescale 1ns/1ps
module seg_desc_decode
  import seg_xlate_pkg::*;
(
  // Raw descriptor words
  input wire logic [63:0] word_lo,
  input wire logic [63:0] word_hi,
  input wire logic wide,
  // Decoded fields
  output logic [63:0] base,
  output desc_attr_t attr
);

  // Base pieces are scattered; the wide form adds the upper 32 bits
  always_comb begin
    base = {32'h0000_0000, word_lo[63:56], word_lo[39:16]};
    if (wide) begin
      base[63:32] = word_hi[31:0];
    end
    attr.present = word_lo[47];
    attr.dpl = word_lo[46:45];
    attr.code_data = word_lo[44];
    attr.seg_type = word_lo[43:40];
  end

endmodule : seg_desc_decode

// ==== test/desc_mem_model.sv ====
// Descriptor memory model that answers the translation unit's fetch port
`timescale 1ns/1ps
module desc_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fetch port
  input wire logic mem_req,
  input wire logic [63:0] mem_addr,
  output logic mem_ack,
  output logic [63:0] mem_rdata,
  // Idle cycles before each answer
  input wire logic [3:0] lat
);
  logic [63:0] words [logic [63:0]];
  logic [3:0] wait_cnt;
  int ack_count;

  // One word per request after lat cycles; data wanders while not answering
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      mem_rdata <= 64'h5A5A_A5A5_5A5A_A5A5;
      ack_count <= 0;
    end else if (mem_req && !mem_ack && wait_cnt >= lat) begin
      mem_ack <= 1'b1;
      wait_cnt <= 4'h0;
      ack_count <= ack_count + 1;
      mem_rdata <= words.exists(mem_addr) ? words[mem_addr] : 64'h0000_0000_0000_0000; // Empty slot is not present
    end else begin
      mem_ack <= 1'b0;
      wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : desc_mem_model

// ==== test/testbench.sv ====
// Self-checking bench for the segment translation unit
`timescale 1ns/1ps
module testbench;
  import seg_xlate_pkg::*;
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mem_req;
  logic [63:0] mem_addr;
  logic mem_ack;
  logic [63:0] mem_rdata;
  logic div_op;
  logic [31:0] div_divisor;
  logic exc_valid;
  logic [7:0] exc_vector;
  logic [31:0] exc_code;
  logic [3:0] lat;
  logic [31:0] rd_data;
  logic rd_err;
  logic [7:0] exc_vec;
  logic [31:0] exc_cd;
  int exc_hits;
  int acks;
  int miscompares;
  int check_count;
  int cycles;

  // Unit under test and its descriptor memory
  seg_xlate uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .div_op(div_op), .div_divisor(div_divisor), .exc_valid(exc_valid), .exc_vector(exc_vector),
    .exc_code(exc_code));
  desc_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));

  // Clock at 125 MHz
  always #4 pclk = ~pclk;

  // Exception pulse catcher and hang guard
  always @(posedge pclk) begin
    cycles++;
    if (exc_valid === 1'b1) begin
      exc_hits++;
      exc_vec = exc_vector;
      exc_cd = exc_code;
    end
    if (cycles == 8000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Exception count, vector and code since the last look
  task automatic chk_exc(input int hits, input logic [7:0] vec, input logic [31:0] code);
    chk("exc count", 64'(hits), 64'(exc_hits));
    if (hits > 0) chk("exc vector", 64'(vec), 64'(exc_vec));
    if (hits > 0) chk("exc code", 64'(code), 64'(exc_cd));
    exc_hits = 0;
  endtask : chk_exc

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("apb ready", 64'h1, 64'(pready));
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic chk_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk(what, 64'(exp), 64'(rd_data));
  endtask : chk_reg

  task automatic chk_lin(input logic [63:0] exp);
    chk_reg("lin lo", ADDR_LIN_LO, exp[31:0]);
    chk_reg("lin hi", ADDR_LIN_HI, exp[63:32]);
  endtask : chk_lin

  // Load selector and offset, then start a translation
  task automatic start(input logic [31:0] sel, input logic [63:0] off);
    acks = mem.ack_count;
    exc_hits = 0;
    wr(ADDR_SEL, sel);
    wr(ADDR_OFF_LO, off[31:0]);
    wr(ADDR_OFF_HI, off[63:32]);
    wr(ADDR_CMD, 32'h0000_0001);
  endtask : start

  task automatic finish_xl(input int fetches);
    for (int i = 0; i < 30; i++) begin
      apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      if (rd_data[0] === 1'b0) break;
    end
    chk("fetch count", 64'(fetches), 64'(mem.ack_count - acks));
  endtask : finish_xl

  function automatic logic [63:0] desc(input logic [31:0] b, input logic p, input logic [1:0] dpl,
    input logic s, input logic [3:0] typ);
    desc = {b[31:24], 8'h00, p, dpl, s, typ, b[23:0], 16'hFFFF};
  endfunction : desc

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    div_op = 1'b0;
    div_divisor = 32'h0000_0001;
    lat = 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state, unmapped access, real-mode translation
    chk_reg("mode", ADDR_MODE, 32'h0000_0000);
    chk_reg("cpl", ADDR_CPL, 32'h0000_0000);
    apb(8'h3C, 1'b0, 32'h0000_0000);
    chk("unmapped err", 64'h1, 64'(rd_err));
    chk("unmapped data", 64'h0, 64'(rd_data));
    wr(ADDR_MODE, 32'h0000_0002);
    chk_reg("ext from real", ADDR_MODE, 32'h0000_0000);
    start(32'h0000_1234, 64'h0000_0000_0000_0005);
    finish_xl(0);
    chk_lin(64'h0000_0000_0001_2345);
    $display("test reset_real done");
    // Protected mode through global and local tables
    wr(ADDR_MODE, 32'h0000_0001);
    wr(ADDR_GT_LO, 32'h0000_1000);
    wr(ADDR_GT_HI, 32'hFFFF_0000);
    wr(ADDR_LT_LO, 32'h0000_2000);
    wr(ADDR_LT_HI, 32'h0000_0001);
    mem.words[64'h0000_0000_0000_1010] = desc(32'h0020_0000, 1'b1, 2'h0, 1'b1, 4'h2);
    mem.words[64'h0000_0000_0000_2008] = desc(32'h0030_0000, 1'b1, 2'h3, 1'b1, 4'hA);
    mem.words[64'h0000_0000_0000_1018] = desc(32'h0040_0000, 1'b0, 2'h3, 1'b1, 4'h2);
    start(32'h0000_0010, 64'h0000_0000_0000_0100);
    finish_xl(1);
    chk_lin(64'h0000_0000_0020_0100);
    chk_reg("attr", ADDR_ATTR, 32'h0000_0092);
    start(32'h0001_000C, 64'h0000_0000_0000_0100);
    finish_xl(1);
    chk_lin(64'h0000_0000_0030_0100);
    chk_reg("cpl load", ADDR_CPL, 32'h0000_0003);
    chk_reg("attr code", ADDR_ATTR, 32'h0000_00FA);
    chk_exc(0, 8'h00, 32'h0000_0000);
    $display("test protected done");
    // Privilege, presence and null selector faults
    start(32'h0000_0010, 64'h0000_0000_0000_0000);
    finish_xl(1);
    chk_exc(1, VEC_GP, 32'h0000_0010);
    chk_reg("status", ADDR_STATUS, 32'h0000_0D04);
    chk_lin(64'h0000_0000_0030_0100);
    start(32'h0000_001B, 64'h0000_0000_0000_0000);
    finish_xl(1);
    chk_exc(1, VEC_GP, 32'h0000_0018);
    chk_reg("errcode", ADDR_ERRCODE, 32'h0000_0018);
    start(32'h0000_0000, 64'h0000_0000_0000_0000);
    finish_xl(0);
    chk_exc(1, VEC_GP, 32'h0000_0000);
    $display("test faults done");
    // 64-bit sub-mode, wide local entry, slow memory, writes refused while busy
    wr(ADDR_MODE, 32'h0000_0002);
    chk_reg("mode 64", ADDR_MODE, 32'h0000_0002);
    mem.words[64'h0000_0001_0000_2010] = desc(32'h4000_0000, 1'b1, 2'h3, 1'b1, 4'h2);
    mem.words[64'h0000_0001_0000_2018] = 64'h0000_0000_0000_0007;
    lat <= 4'h3;
    start(32'h0000_000F, 64'h0000_0001_0000_0010);
    // Vector of the last fault stays visible until a new fault replaces it
    chk_reg("busy", ADDR_STATUS, 32'h0000_0D01);
    wr(ADDR_GT_LO, 32'h0000_DEAD);
    finish_xl(2);
    chk_lin(64'h0000_0008_4000_0010);
    chk_reg("gt kept", ADDR_GT_LO, 32'h0000_1000);
    lat <= 4'h0;
    $display("test wide done");
    // Compatibility sub-mode keeps legacy entries and 32-bit sums
    wr(ADDR_MODE, 32'h0000_0003);
    chk_reg("mode compat", ADDR_MODE, 32'h0000_0003);
    mem.words[64'h0000_0001_0000_2008] = desc(32'hFFFF_F000, 1'b1, 2'h3, 1'b1, 4'h2);
    start(32'h0000_000F, 64'h0000_0000_0000_2000);
    finish_xl(1);
    chk_lin(64'h0000_0000_0000_1000);
    $display("test compat done");
    // Divide check
    exc_hits = 0;
    div_divisor <= 32'h0000_0007;
    div_op <= 1'b1;
    @(posedge pclk);
    div_divisor <= 32'h0000_0000;
    @(posedge pclk);
    div_op <= 1'b0;
    repeat (3) @(posedge pclk);
    chk_exc(1, VEC_DE, 32'h0000_0000);
    $display("test divide done");
    // Reset in mid-run returns to real mode
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_reg("mode again", ADDR_MODE, 32'h0000_0000);
    chk_reg("cpl again", ADDR_CPL, 32'h0000_0000);
    chk_reg("gt again", ADDR_GT_HI, 32'h0000_0000);
    $display("test rereset done");
    report_and_stop();
  end
endmodule : testbench
